//--- hdl/batch_sequence_control.sv
// Batch sequencer with setpoint evaluation and AHB-Lite registers
//
// The address map and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
`include "batch_seq_map.svh"
module batch_sequence_control
(
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	// AHB-Lite
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic                  hready,
	input  wire logic [31:0]           hwdata,
	output logic [31:0]                hrdata,
	output logic                       hreadyout,
	output logic                       hresp,
	// Digital inputs, active low
	input  wire logic                  din1_n,
	input  wire logic                  din2_n,
	// Scale side
	input  wire logic [`WT_W-1:0]      gross_weight,
	input  wire logic                  standstill,
	// Outputs
	output logic [`OUT_NUM-1:0]        dig_out,
	output logic                       tare_req,
	output logic                       net_mode,
	output logic                       print_req,
	output logic                       batch_active
);
	import batch_seq_pkg::*;
	localparam int N = `SP_NUM;
	// Setpoint table
	sp_kind_e          kind_r  [N];
	trip_mode_e        trip_r  [N];
	access_e           acc_r   [N];
	logic              en_r    [N];
	logic              tare_r  [N];
	logic              prt_r   [N];
	logic [1:0]        dout_r  [N];
	logic              douten_r[N];
	logic [2:0]        ref_r   [N];
	logic [2:0]        sidx_r  [N];
	logic [2:0]        eidx_r  [N];
	logic [`WT_W-1:0]  val_r   [N];
	logic [`WT_W-1:0]  band_r  [N];
	logic [`WT_W-1:0]  refw_r  [N];
	logic [7:0]        insel_r;
	logic [2:0]        sel_r;
	logic [`WT_W-1:0]  tare_w_r;
	logic              prev_start_r;
	logic [2:0]        step_r;
	seq_state_e        st_r;
	logic              hold_r;
	logic [`OUT_NUM-1:0] hyst_r;
	logic [`OUT_NUM-1:0] olap_r;
	logic [`OUT_NUM-1:0] wdog_r;
	logic              wr_en;
	logic              rd_en;
	logic [7:0]        addr;
	logic              start_lvl;
	logic              run_lvl;
	logic              start_edge;
	logic              run_fn;
	logic [`WT_W-1:0]  net_w;
	logic              tripped;
	logic              abort_req;
	logic [N-1:0]      tmr_exp;
	ahb_regs u_bus
	(
		.sys_clk   (sys_clk),
		.rst_n     (rst_n),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.wr_en     (wr_en),
		.rd_en     (rd_en),
		.addr      (addr)
	);

	// Input function routing
	function automatic logic fn_level(input logic [3:0] fn);
		fn_level = (insel_r[3:0] == fn) ? !din1_n
			: (insel_r[7:4] == fn) ? !din2_n : 1'b0;
	endfunction
	assign run_fn    = (insel_r[3:0] == `FN_RUN) || (insel_r[7:4] == `FN_RUN);
	assign start_lvl = fn_level(`FN_START);
	assign run_lvl   = run_fn ? fn_level(`FN_RUN) : 1'b1;
	assign start_edge = start_lvl && !prev_start_r && run_lvl;
	assign net_w     = gross_weight - tare_w_r;
	assign abort_req = wr_en && addr == `REG_CTRL &&
		(hwdata[`CTRL_ABORT] || hwdata[`CTRL_REINIT]);
	assign batch_active = (st_r == SEQ_RUN);
	// Trip evaluation of the current step
	always_comb
	begin
		logic [`WT_W-1:0] w;
		w = net_mode ? net_w : gross_weight;
		tripped = 1'b0;
		case (kind_r[step_r])
			K_GROSS,
			K_NET:
			begin
				w = (kind_r[step_r] == K_GROSS) ? gross_weight : net_w;
				case (trip_r[step_r])
					T_HIGHER: tripped = w >= val_r[step_r];
					T_LOWER:  tripped = w < val_r[step_r];
					T_WITHIN_BAND_TRIP: tripped = (w + band_r[step_r] >= val_r[step_r])
						&& (w <= val_r[step_r] + band_r[step_r]);
					default:  tripped = 1'b0;
				endcase
			end
			K_BELOW_REF:
				tripped = w + val_r[step_r] <=
					refw_r[ref_r[step_r]];
			K_STANDSTILL: tripped = standstill;
			default:      tripped = 1'b1;
		endcase
	end

	// Input edge history
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			prev_start_r <= 1'b0;
		else
			prev_start_r <= start_lvl;
	end

	// Sequencer
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_r   <= SEQ_IDLE;
			step_r <= 3'h0;
			hold_r <= 1'b0;
		end
		else if (abort_req)
		begin
			st_r   <= SEQ_IDLE;
			step_r <= 3'h0;
			hold_r <= 1'b0;
		end
		else
		begin
			case (st_r)
				SEQ_IDLE,
				SEQ_HALT:
					if (start_edge)
						st_r <= SEQ_RUN;
				SEQ_RUN:
					if (!run_lvl)
						st_r <= SEQ_HALT;
					else if (hold_r ? standstill : (!en_r[step_r] || tripped))
					begin
						if (!hold_r && en_r[step_r] && prt_r[step_r]
							&& !standstill)
							hold_r <= 1'b1;
						else
						begin
							hold_r <= 1'b0;
							step_r <= step_r + 3'h1;
							if (step_r == 3'(N - 1))
								st_r <= SEQ_IDLE;
						end
					end
				default: st_r <= SEQ_IDLE;
			endcase
		end
	end

	// Tare, print and reference capture
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tare_w_r  <= 24'h0;
			net_mode  <= 1'b0;
			tare_req  <= 1'b0;
			print_req <= 1'b0;
			for (int i = 0; i < N; i++)
				refw_r[i] <= 24'h0;
		end
		else
		begin
			tare_req <= 1'b0;
			if (wr_en && addr == `REG_CTRL && hwdata[`CTRL_PRINT_ACK])
				print_req <= 1'b0;
			if (st_r == SEQ_RUN && run_lvl && en_r[step_r])
			begin
				if (!hold_r && tripped)
				begin
					refw_r[step_r] <= net_mode ? net_w : gross_weight;
					if (kind_r[step_r] == K_STANDSTILL && tare_r[step_r])
					begin
						tare_w_r <= gross_weight;
						net_mode <= 1'b1;
						tare_req <= 1'b1;
					end
					if (prt_r[step_r] && standstill)
						print_req <= 1'b1;
				end
				else if (hold_r && standstill)
					print_req <= 1'b1;
			end
		end
	end

	// Per-output hysteresis, overlap and watchdog
	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : g_sp
			tenth_timer u_tmr
			(
				.sys_clk (sys_clk),
				.rst_n   (rst_n),
				.arm     (st_r == SEQ_RUN && step_r == sidx_r[g]
					&& kind_r[g] == K_TIMER && en_r[g]),
				.stop    (abort_req || step_r == eidx_r[g]
					|| st_r == SEQ_IDLE),
				.tenths  (val_r[g][15:0]),
				.expired (tmr_exp[g])
			);
		end
	endgenerate

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			{hyst_r, olap_r, wdog_r} <= '0;
		else
		begin
			{hyst_r, olap_r, wdog_r} <= '0;
			for (int i = 0; i < N; i++)
			begin
				if (en_r[i] && douten_r[i])
				begin
					if (kind_r[i] == K_GROSS && band_r[i] != 24'h0
						&& trip_r[i] == T_HIGHER)
					begin
						if (gross_weight < val_r[i])
							hyst_r[dout_r[i]] <= 1'b1;
						else if (gross_weight < val_r[i] + band_r[i])
							hyst_r[dout_r[i]] <= dig_out[dout_r[i]];
					end
					if (kind_r[i] == K_OVERLAP && val_r[i] == 24'h0
						&& st_r != SEQ_IDLE && step_r >= sidx_r[i]
						&& step_r < eidx_r[i])
						olap_r[dout_r[i]] <= 1'b1;
					if (kind_r[i] == K_TIMER && tmr_exp[i])
						wdog_r[dout_r[i]] <= 1'b1;
				end
			end
		end
	end

	// Feed output of current step
	logic [`OUT_NUM-1:0] feed;
	always_comb
	begin
		feed = '0;
		if (st_r == SEQ_RUN && en_r[step_r] && douten_r[step_r] && !tripped
			&& !hold_r && (kind_r[step_r] == K_NET
			|| kind_r[step_r] == K_BELOW_REF))
			feed[dout_r[step_r]] = 1'b1;
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			dig_out <= '0;
		else
			dig_out <= feed | hyst_r | olap_r | wdog_r;
	end

	// Register writes
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			insel_r <= `INSEL_RESET;
			sel_r   <= 3'h0;
			for (int i = 0; i < N; i++)
			begin
				kind_r[i]   <= K_OFF;
				trip_r[i]   <= T_HIGHER;
				acc_r[i]    <= ACC_ON;
				en_r[i]     <= 1'b0;
				tare_r[i]   <= 1'b0;
				prt_r[i]    <= 1'b0;
				dout_r[i]   <= 2'h0;
				douten_r[i] <= 1'b0;
				ref_r[i]    <= 3'h0;
				sidx_r[i]   <= 3'h0;
				eidx_r[i]   <= 3'h0;
				val_r[i]    <= 24'h0;
				band_r[i]   <= 24'h0;
			end
		end
		else if (wr_en)
		begin
			case (addr)
				`REG_INSEL: insel_r <= hwdata[7:0];
				`REG_SEL:   sel_r   <= hwdata[2:0];
				`REG_CFG:
				begin
					kind_r[sel_r]   <= sp_kind_e'(hwdata[3:0]);
					trip_r[sel_r]   <= trip_mode_e'(hwdata[5:4]);
					acc_r[sel_r]    <= access_e'(hwdata[7:6]);
					tare_r[sel_r]   <= hwdata[8];
					prt_r[sel_r]    <= hwdata[9];
					dout_r[sel_r]   <= hwdata[11:10];
					douten_r[sel_r] <= hwdata[12];
					ref_r[sel_r]    <= hwdata[15:13];
					sidx_r[sel_r]   <= hwdata[18:16];
					eidx_r[sel_r]   <= hwdata[21:19];
					en_r[sel_r]     <= hwdata[22];
				end
				`REG_VAL:
					if (acc_r[sel_r] == ACC_ON)
						val_r[sel_r] <= hwdata[`WT_W-1:0];
				`REG_BAND:
					if (acc_r[sel_r] == ACC_ON)
						band_r[sel_r] <= hwdata[`WT_W-1:0];
				`REG_KEY:
					if (acc_r[sel_r] == ACC_ON && st_r != SEQ_RUN)
						en_r[sel_r] <= hwdata[0];
				default: ;
			endcase
		end
	end

	// Register reads
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			hrdata <= 32'h0;
		else if (rd_en)
		begin
			case (addr)
				`REG_STATUS: hrdata <= {20'h0, print_req, net_mode, hold_r,
					step_r, 4'(st_r), run_lvl, start_lvl};
				`REG_INSEL:  hrdata <= {24'h0, insel_r};
				`REG_WEIGHT: hrdata <= {8'h0, gross_weight};
				`REG_TARE:   hrdata <= {8'h0, tare_w_r};
				`REG_OUTS:   hrdata <= {28'h0, dig_out};
				`REG_SEL:    hrdata <= {29'h0, sel_r};
				`REG_CFG:    hrdata <= {9'h0, en_r[sel_r], eidx_r[sel_r],
					sidx_r[sel_r], ref_r[sel_r], douten_r[sel_r],
					dout_r[sel_r], prt_r[sel_r], tare_r[sel_r],
					2'(acc_r[sel_r]), 2'(trip_r[sel_r]), 4'(kind_r[sel_r])};
				`REG_VAL:    hrdata <= (acc_r[sel_r] == ACC_HIDE) ? 32'h0
					: {8'h0, val_r[sel_r]};
				`REG_BAND:   hrdata <= {8'h0, band_r[sel_r]};
				default:     hrdata <= 32'h0;
			endcase
		end
	end
endmodule

//--- hdl/batch_seq_map.svh
// Constants for the batch sequence controller
//   Function
// - Batch start is accepted only while active-low batch run input is asserted.
// - With no input given the run function, batch run counts as always asserted.
// - Start activity is ignored while run is deasserted by the stop control.
// - Deasserting run during a batch halts at once and keeps the step.
// - Reasserting run then pulsing start resumes from the saved step.
// - Abort resets the step pointer; run and start then restart from step one.
// - After reset input one is batch start and input two is batch run.
// - Gross or net higher threshold trips when weight reaches or exceeds value.
// - Standstill step with tare waits for standstill, then tares and goes net.
// - Below-reference step trips at value under the captured reference weight.
// - Hysteresis step drives output below value until value plus band reached.
// - Timer step starts at start setpoint, alarms if end not reached in time.
// - Zero-value overlap step drives output from start step until end step.
// - In-band step trips only while weight lies within value plus or minus band.
// - Feed step output stays on while pending and turns off on trip.
// - Print-on-trip with standstill wait requests a print once at standstill.
// - Protection on allows edit, off blocks change, hide blocks change and view; the code hides only the value, the band still reads back.
// - Keypad enable or disable of unprotected setpoint only while batch idle; the code also accepts it while the batch is halted.
// - Timer values count in tenths of a second.
`ifndef BATCH_SEQ_MAP_SVH
`define BATCH_SEQ_MAP_SVH

`define SP_NUM          8
`define SP_IDX_W        3
`define WT_W            24
`define OUT_NUM         4
`define CLK_HZ          20000000
`define TENTH_NS        100000000
`define CLK_NS          50
`define TENTH_CYC       (`TENTH_NS / `CLK_NS)

`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_INSEL       8'h08
`define REG_WEIGHT      8'h0C
`define REG_TARE        8'h10
`define REG_OUTS        8'h14
`define REG_SEL         8'h18
`define REG_CFG         8'h1C
`define REG_VAL         8'h20
`define REG_BAND        8'h24
`define REG_KEY         8'h28

`define CTRL_ABORT      0
`define CTRL_REINIT     1
`define CTRL_PRINT_ACK  2
`define INSEL_RESET     8'h21
`define FN_NONE         4'h0
`define FN_START        4'h1
`define FN_RUN          4'h2

`endif

//--- hdl/batch_seq_pkg.sv
// Types for the batch sequence controller
package batch_seq_pkg;
	typedef enum logic [3:0] {
		K_OFF,
		K_GROSS,
		K_NET,
		K_BELOW_REF,
		K_STANDSTILL,
		K_TIMER,
		K_OVERLAP
	} sp_kind_e;
	typedef enum logic [1:0] {
		T_HIGHER,
		T_LOWER,
		T_WITHIN_BAND_TRIP
	} trip_mode_e;
	typedef enum logic [1:0] {
		ACC_ON,
		ACC_OFF,
		ACC_HIDE
	} access_e;
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_RUN,
		SEQ_HALT
	} seq_state_e;
endpackage

//--- hdl/tenth_timer.sv
// Watchdog counter in tenths of a second
`timescale 1ns/1ps
`include "batch_seq_map.svh"
module tenth_timer
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// Control
	input  wire logic        arm,
	input  wire logic        stop,
	input  wire logic [15:0] tenths,
	// Status
	output logic             expired
);
	localparam int unsigned TC = `TENTH_CYC;
	logic [21:0] pre_r;
	logic [15:0] cnt_r;
	logic        live_r;

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pre_r   <= 22'h0;
			cnt_r   <= 16'h0;
			live_r  <= 1'b0;
			expired <= 1'b0;
		end
		else if (stop)
		begin
			live_r  <= 1'b0;
			expired <= 1'b0;
		end
		else if (arm && !live_r)
		begin
			live_r <= 1'b1;
			pre_r  <= 22'h0;
			cnt_r  <= tenths;
		end
		else if (live_r && !expired)
		begin
			if (cnt_r == 16'h0)
				expired <= 1'b1;
			else if (pre_r == 22'(TC - 1))
			begin
				pre_r <= 22'h0;
				cnt_r <= cnt_r - 16'h1;
			end
			else
				pre_r <= pre_r + 22'h1;
		end
	end
endmodule

//--- hdl/ahb_regs.sv
// AHB-Lite slave front end, zero wait states
`timescale 1ns/1ps
module ahb_regs
(
	// AHB-Lite
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	// Register side
	output logic             wr_en,
	output logic             rd_en,
	output logic [7:0]       addr
);
	logic       wpend_r;
	logic [7:0] a_r;
	logic       take;

	assign take      = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign wr_en     = wpend_r;
	assign rd_en     = take && !hwrite;
	assign addr      = wpend_r ? a_r : haddr[7:0];

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wpend_r <= 1'b0;
			a_r     <= 8'h0;
		end
		else
		begin
			wpend_r <= take && hwrite && (hsize == 3'h2);
			a_r     <= haddr[7:0];
		end
	end
endmodule

//--- verification/batch_seq_monitor.sv
// Port checker for the batch sequence controller
`timescale 1ns/1ps
module batch_seq_monitor
(
	// Clock and reset
	input	wire logic		sys_clk,
	input	wire logic		rst_n,
	// Bus
	input	wire logic		hsel,
	input	wire logic [1:0]	htrans,
	input	wire logic		hwrite,
	input	wire logic		hready,
	input	wire logic [31:0]	hrdata,
	input	wire logic		hreadyout,
	input	wire logic		hresp,
	// Process side
	input	wire logic		din1_n,
	input	wire logic		standstill,
	input	wire logic		tare_req,
	input	wire logic		net_mode,
	input	wire logic		print_req,
	input	wire logic		batch_active
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	logic	rd_take_r;

	// Read taken in the previous cycle
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			rd_take_r <= 1'b0;
		else
			rd_take_r <= hsel && hready && htrans[1] && !hwrite;
	end

	bus_ready_a: assert property (hreadyout)
		else $error("slave not ready");
	bus_okay_a: assert property (!hresp)
		else $error("error response");
	rdata_hold_a: assert property (!rd_take_r |-> $stable(hrdata))
		else $error("read data changed without read");
	start_edge_a: assert property ($rose(batch_active) |->
		!$past(din1_n) && $past(din1_n, 2))
		else $error("batch began without start edge");
	tare_pulse_a: assert property (tare_req |=> !tare_req)
		else $error("tare request longer than a cycle");
	tare_net_a: assert property (tare_req |-> ##[0:1] net_mode)
		else $error("no net mode after tare");
	tare_still_a: assert property (tare_req |-> $past(standstill))
		else $error("tare without standstill");
	print_still_a: assert property (
		$rose(print_req) |-> $past(standstill))
		else $error("print without standstill");
endmodule

bind batch_sequence_control batch_seq_monitor batch_seq_monitor_inst (
	.sys_clk, .rst_n, .hsel, .htrans, .hwrite, .hready, .hrdata,
	.hreadyout, .hresp, .din1_n, .standstill, .tare_req, .net_mode,
	.print_req, .batch_active);

//--- verification/batch_switch_model.sv
// Operator batch switch unit model
`timescale 1ns/1ps
module batch_switch_model
#(
	parameter int	HOLD = 4
)
(
	// Clock and reset
	input	wire logic	sys_clk,
	input	wire logic	rst_n,
	// Operator actions
	input	wire logic	press_start,
	input	wire logic	stop_locked,
	// Digital inputs, active low
	output	logic		din1_n,
	output	logic		din2_n
);
	logic [3:0]	hold_r;

	// Momentary start contact
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			hold_r <= 4'h0;
		else if (press_start)
			hold_r <= HOLD[3:0];
		else if (hold_r != 4'h0)
			hold_r <= hold_r - 4'h1;
	end
	assign din1_n = (hold_r == 4'h0);
	// Locked stop opens the run contact
	assign din2_n = stop_locked;
endmodule

//--- verification/tb.sv
// Testbench for the batch sequence controller
`timescale 1ns/1ps
`include "batch_seq_map.svh"
module tb;
	logic			sys_clk = 1'b0;
	logic			rst_n = 1'b0;
	logic			hsel = 1'b0;
	logic [31:0]		haddr = 32'h0;
	logic [1:0]		htrans = 2'h0;
	logic			hwrite = 1'b0;
	logic [2:0]		hsize = 3'h2;
	logic [31:0]		hwdata = 32'h0;
	logic [`WT_W-1:0]	gross_weight = '0;
	logic			standstill = 1'b0;
	logic			press = 1'b0;
	logic			stop = 1'b0;
	logic			rd_ph = 1'b0;
	logic [31:0]		hrdata;
	logic [31:0]		rv;
	logic [`OUT_NUM-1:0]	dig_out;
	logic			hreadyout, hresp, din1_n, din2_n;
	logic			tare_req, net_mode, print_req, batch_active;
	logic [31:0]		exp_q[$];
	logic [31:0]		msk_q[$];
	int			miscompares = 0;
	int			total_checks = 0;
	int			cyc = 0;

	always #25 sys_clk = ~sys_clk;

	batch_sequence_control batch_sequence_control_inst (.sys_clk, .rst_n,
		.hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout),
		.hwdata, .hrdata, .hreadyout, .hresp, .din1_n, .din2_n,
		.gross_weight, .standstill, .dig_out, .tare_req, .net_mode,
		.print_req, .batch_active);
	batch_switch_model batch_switch_model_inst (.sys_clk, .rst_n,
		.press_start(press), .stop_locked(stop), .din1_n, .din2_n);

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Single word transfer; reads note data and mask for the watcher
	task automatic bus(input logic [7:0] a, input logic wr,
		input logic [31:0] d, input logic [31:0] m);
		@(posedge sys_clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge sys_clk);
		while (hreadyout !== 1'b1) @(posedge sys_clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		if (!wr)
		begin
			exp_q.push_back(d);
			msk_q.push_back(m);
			rd_ph <= 1'b1;
		end
		@(posedge sys_clk);
		while (hreadyout !== 1'b1) @(posedge sys_clk);
		rd_ph <= 1'b0;
	endtask

	task automatic press_start();
		press <= 1'b1;
		@(posedge sys_clk);
		press <= 1'b0;
		repeat (5) @(posedge sys_clk);
	endtask

	// Read data watcher and hang limit
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (rd_ph && hreadyout === 1'b1)
		begin
			chk(hrdata & msk_q[0], exp_q[0]);
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
		if (cyc == 3000)
		begin
			miscompares++;
			wrap_up();
		end
	end

	initial
	begin
		void'($urandom(2876));
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		bus(`REG_INSEL, 1'b0, 32'h21, 32'hFF);
		bus(8'h40, 1'b0, 32'h0, 32'hFFFFFFFF);
		// Edit accepted with access on, ignored with access off
		rv = $urandom & 32'hFFFF;
		bus(`REG_SEL, 1'b1, 32'h7, 32'h0);
		bus(`REG_VAL, 1'b1, rv, 32'h0);
		bus(`REG_VAL, 1'b0, rv, 32'hFFFF);
		bus(`REG_CFG, 1'b1, 32'h40, 32'h0);
		bus(`REG_VAL, 1'b1, ~rv, 32'h0);
		bus(`REG_VAL, 1'b0, rv, 32'hFFFF);
		// Gross 300, standstill tare, net 100 feed with print
		bus(`REG_SEL, 1'b1, 32'h0, 32'h0);
		bus(`REG_CFG, 1'b1, 32'h400001, 32'h0);
		bus(`REG_VAL, 1'b1, 32'h12C, 32'h0);
		bus(`REG_SEL, 1'b1, 32'h1, 32'h0);
		bus(`REG_CFG, 1'b1, 32'h400104, 32'h0);
		bus(`REG_SEL, 1'b1, 32'h2, 32'h0);
		bus(`REG_CFG, 1'b1, 32'h401602, 32'h0);
		bus(`REG_VAL, 1'b1, 32'h64, 32'h0);
		gross_weight <= 24'($urandom_range(299, 1));
		stop <= 1'b1;
		press_start();
		chk({31'h0, batch_active}, 32'h0);
		stop <= 1'b0;
		press_start();
		chk({31'h0, batch_active}, 32'h1);
		gross_weight <= 24'h12C;
		repeat (4) @(posedge sys_clk);
		stop <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk({31'h0, batch_active}, 32'h0);
		bus(`REG_STATUS, 1'b0, 32'h48, 32'h1FC);
		press_start();
		bus(`REG_STATUS, 1'b0, 32'h48, 32'h1FC);
		stop <= 1'b0;
		press_start();
		bus(`REG_STATUS, 1'b0, 32'h44, 32'h1FC);
		standstill <= 1'b1;
		repeat (6) @(posedge sys_clk);
		chk({28'h0, dig_out}, 32'h2);
		chk({31'h0, net_mode}, 32'h1);
		gross_weight <= 24'h190;
		repeat (6) @(posedge sys_clk);
		chk({28'h0, dig_out}, 32'h0);
		chk({31'h0, print_req}, 32'h1);
		bus(`REG_CTRL, 1'b1, 32'h4, 32'h0);
		repeat (2) @(posedge sys_clk);
		chk({31'h0, print_req}, 32'h0);
		// Run function unassigned: stop has no effect
		bus(`REG_INSEL, 1'b1, 32'h1, 32'h0);
		stop <= 1'b1;
		standstill <= 1'b0;
		gross_weight <= 24'h12C;
		press_start();
		chk({31'h0, batch_active}, 32'h1);
		bus(`REG_SEL, 1'b1, 32'h0, 32'h0);
		bus(`REG_KEY, 1'b1, 32'h0, 32'h0);
		bus(`REG_CFG, 1'b0, 32'h400000, 32'h400000);
		bus(`REG_STATUS, 1'b0, 32'h44, 32'h1FC);
		bus(`REG_CTRL, 1'b1, 32'h1, 32'h0);
		bus(`REG_STATUS, 1'b0, 32'h0, 32'h1FC);
		bus(`REG_KEY, 1'b1, 32'h0, 32'h0);
		bus(`REG_CFG, 1'b0, 32'h0, 32'h400000);
		bus(`REG_KEY, 1'b1, 32'h1, 32'h0);
		bus(`REG_CFG, 1'b0, 32'h400000, 32'h400000);
		// Hidden value reads as zero
		bus(`REG_SEL, 1'b1, 32'h7, 32'h0);
		bus(`REG_CFG, 1'b1, 32'h80, 32'h0);
		bus(`REG_VAL, 1'b0, 32'h0, 32'hFFFF);
		// Refill band on output two
		bus(`REG_SEL, 1'b1, 32'h3, 32'h0);
		bus(`REG_CFG, 1'b1, 32'h401801, 32'h0);
		bus(`REG_VAL, 1'b1, 32'h12C, 32'h0);
		bus(`REG_BAND, 1'b1, 32'h2BC, 32'h0);
		gross_weight <= 24'hC8;
		repeat (3) @(posedge sys_clk);
		chk({28'h0, dig_out}, 32'h4);
		gross_weight <= 24'($urandom_range(999, 301));
		repeat (3) @(posedge sys_clk);
		chk({28'h0, dig_out}, 32'h4);
		gross_weight <= 24'h3E8;
		repeat (3) @(posedge sys_clk);
		chk({28'h0, dig_out}, 32'h0);
		// Overlap and zero-length watchdog over the first step
		bus(`REG_SEL, 1'b1, 32'h4, 32'h0);
		bus(`REG_CFG, 1'b1, 32'h481C06, 32'h0);
		bus(`REG_SEL, 1'b1, 32'h5, 32'h0);
		bus(`REG_CFG, 1'b1, 32'h481005, 32'h0);
		gross_weight <= 24'h64;
		press_start();
		repeat (2) @(posedge sys_clk);
		chk({28'h0, dig_out}, 32'hD);
		gross_weight <= 24'h12C;
		repeat (5) @(posedge sys_clk);
		chk({28'h0, dig_out}, 32'h4);
		wrap_up();
	end
endmodule
